// file: usb_regs_consts.vh
`ifndef USB_REGS_CONSTS_VH
`define USB_REGS_CONSTS_VH
`define PIPE_BUF_ADDR_IDX     4'h0
`define PIPE_PKT_SIZE_IDX     4'h4
`define PIPE_EXT_TOKEN_IDX    4'h8
`define PIPE_BANK_STAT_IDX    4'ha
`define PIPE_CTRL_IDX         4'hc
`define PIPE_ERR_STAT_IDX     4'he
`define IRQ_EN_CLEAR_OFS      8'h14
`define IRQ_EN_SET_OFS        8'h18
`define IRQ_FLAG_OFS          8'h1c
`define IRQ_STATUS_OFS        8'h20
`define IRQ_MASK_OFS          8'h24
`define PROTECT_OFS           8'h28
`define PIPE_BASE_OFS         8'h40
`define IRQ_EN_RESET          16'h0000
`define IRQ_EN_VALID          16'h03bd
`define BIT_LPM_SUSP          9
`define BIT_LPM_NYET          8
`define BIT_RAM_ACC_ERR       7
`define UNMAPPED_DATA         32'h00000000
`endif

// file: irq_enable_bank.v
`timescale 1ns/1ps
`include "usb_regs_consts.vh"
module irq_enable_bank (
  input  wire        clk,
  input  wire        rstn,
  input  wire        set_we,
  input  wire        clr_we,
  input  wire [15:0] wdata,
  input  wire [15:0] flags,
  output reg  [15:0] enable_reg,
  output wire        irq_req
);
  wire [15:0] enable_next;
  // One shared store seen through both set and clear views
  assign enable_next = set_we ? (enable_reg | (wdata & `IRQ_EN_VALID)) :
                       clr_we ? (enable_reg & ~wdata) : enable_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      enable_reg <= `IRQ_EN_RESET;
    else
      enable_reg <= enable_next;
  end
  assign irq_req = |(flags & enable_reg);
endmodule

// file: event_status.v
`timescale 1ns/1ps
`include "usb_regs_consts.vh"
module event_status (
  input  wire        clk,
  input  wire        rstn,
  input  wire [15:0] events,
  input  wire        rd_clear,
  output reg  [15:0] status_reg
);
  // Set wins over the read clear so no event is lost
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      status_reg <= 16'h0000;
    else if (rd_clear)
      status_reg <= events;
    else
      status_reg <= status_reg | events;
  end
endmodule

// file: usb_pipe_desc_irq_enable_set.v
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "usb_regs_consts.vh"
// How it works
// - Writing zero to an enable set bit leaves that enable unchanged.
// - Writing one to bit 9 sets the link suspend interrupt enable.
// - Writing one to bit 8 sets the link not-yet interrupt enable.
// - Writing one to bit 7 sets the RAM access error enable.
// - Set and clear registers share one set of enable bits.
// - Reading an enable bit returns one when enabled, zero otherwise.
// - Enables reset to zero; protection blocks enable, mask and descriptor writes but not flag clears.
module usb_pipe_desc_irq_enable_set (
  input  wire        CLK_SYS,
  input  wire        RSTN,
  input  wire [7:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  input  wire [15:0] SOURCE_FLAGS,
  input  wire        WRITE_PROTECT,
  output wire        USB_IRQ,
  output wire        EVENT_IRQ
);
  reg  [31:0] pipe_mem [0:5];
  reg  [15:0] flag_reg;
  reg  [15:0] mask_reg;
  reg         ack_reg;
  reg         wp_s1_reg;
  reg         wp_s2_reg;
  reg         wp_s3_reg;
  reg         wp_reg;
  wire [15:0] enable_reg;
  wire [15:0] status_reg;
  wire [15:0] flag_rise;
  wire        access;
  wire        wr_ok;
  wire        pipe_hit;
  wire [7:0]  pipe_ofs;
  wire [2:0]  pipe_idx;
  wire [31:0] bmask;
  wire        en_irq;
  integer     i;

  function [2:0] pipe_slot;
    input [7:0] a;
    begin
      case (a[3:0])
        `PIPE_BUF_ADDR_IDX:  pipe_slot = 3'h0;
        `PIPE_PKT_SIZE_IDX:  pipe_slot = 3'h1;
        `PIPE_EXT_TOKEN_IDX: pipe_slot = 3'h2;
        `PIPE_BANK_STAT_IDX: pipe_slot = 3'h3;
        `PIPE_CTRL_IDX:      pipe_slot = 3'h4;
        `PIPE_ERR_STAT_IDX:  pipe_slot = 3'h5;
        default:             pipe_slot = 3'h7;
      endcase
    end
  endfunction

  // Descriptor indices count words, so byte address is four times index
  assign pipe_ofs = AVS_ADDRESS - `PIPE_BASE_OFS;
  assign pipe_idx = pipe_slot({2'h0, pipe_ofs[7:2]});
  assign pipe_hit = (AVS_ADDRESS >= `PIPE_BASE_OFS) && (AVS_ADDRESS < 8'h80) &&
                    (AVS_ADDRESS[1:0] == 2'h0) && (pipe_idx != 3'h7);
  assign access   = (AVS_READ | AVS_WRITE) & ~ack_reg;
  // One wait cycle per access; answer at the second edge
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign wr_ok    = AVS_WRITE & ack_reg & ~wp_reg;
  assign bmask    = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                     {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // Protect level is from outside the clock domain
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
      wp_s3_reg <= 1'b0;
      wp_reg    <= 1'b0;
    end else begin
      wp_s1_reg <= WRITE_PROTECT;
      wp_s2_reg <= wp_s1_reg;
      wp_s3_reg <= wp_s2_reg;
      if (wp_s2_reg == wp_s3_reg)
        wp_reg <= wp_s3_reg;
    end
  end

  irq_enable_bank u_en (
    .clk        (CLK_SYS),
    .rstn       (RSTN),
    .set_we     (wr_ok && AVS_ADDRESS == `IRQ_EN_SET_OFS),
    .clr_we     (wr_ok && AVS_ADDRESS == `IRQ_EN_CLEAR_OFS),
    .wdata      (AVS_WRITEDATA[15:0] & bmask[15:0]),
    .flags      (flag_reg),
    .enable_reg (enable_reg),
    .irq_req    (en_irq)
  );
  assign USB_IRQ = en_irq;

  // Source flags are synchronous to CLK_SYS; flag bits are write-one-to-clear
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN)
      flag_reg <= 16'h0000;
    else if (AVS_WRITE && ack_reg && AVS_ADDRESS == `IRQ_FLAG_OFS)
      flag_reg <= (flag_reg & ~(AVS_WRITEDATA[15:0] & bmask[15:0])) | SOURCE_FLAGS;
    else
      flag_reg <= flag_reg | SOURCE_FLAGS;
  end

  assign flag_rise = SOURCE_FLAGS & ~flag_reg;
  event_status u_evt (
    .clk        (CLK_SYS),
    .rstn       (RSTN),
    .events     (flag_rise),
    // Clear on the edge that captures read data, so no event slips in between
    .rd_clear   (access && AVS_READ && AVS_ADDRESS == `IRQ_STATUS_OFS),
    .status_reg (status_reg)
  );
  assign EVENT_IRQ = |(status_reg & mask_reg);

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ack_reg      <= 1'b0;
      mask_reg     <= 16'h0000;
      AVS_READDATA <= 32'h00000000;
      for (i = 0; i < 6; i = i + 1)
        pipe_mem[i] <= 32'h00000000;
    end else begin
      ack_reg <= access;
      if (wr_ok && AVS_ADDRESS == `IRQ_MASK_OFS)
        mask_reg <= (mask_reg & ~bmask[15:0]) | (AVS_WRITEDATA[15:0] & bmask[15:0]);
      if (wr_ok && pipe_hit)
        pipe_mem[pipe_idx] <= (pipe_mem[pipe_idx] & ~bmask) | (AVS_WRITEDATA & bmask);
      if (access && AVS_READ) begin
        if (pipe_hit)
          AVS_READDATA <= pipe_mem[pipe_idx];
        else
          case (AVS_ADDRESS)
            `IRQ_EN_SET_OFS,
            `IRQ_EN_CLEAR_OFS: AVS_READDATA <= {16'h0000, enable_reg};
            `IRQ_FLAG_OFS:     AVS_READDATA <= {16'h0000, flag_reg};
            `IRQ_STATUS_OFS:   AVS_READDATA <= {16'h0000, status_reg};
            `IRQ_MASK_OFS:     AVS_READDATA <= {16'h0000, mask_reg};
            `PROTECT_OFS:      AVS_READDATA <= {31'h00000000, wp_reg};
            default:           AVS_READDATA <= `UNMAPPED_DATA;
          endcase
      end
    end
  end
endmodule

// file: usb_irq_props.sv
`timescale 1ns/1ps
module usb_irq_props (
  input wire        CLK_SYS,
  input wire        RSTN,
  input wire [7:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0]  AVS_BYTEENABLE,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire [15:0] SOURCE_FLAGS,
  input wire        WRITE_PROTECT,
  input wire        USB_IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence rd_done(a); AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == a; endsequence
  // Depth 5 keeps clear of the protect synchroniser
  sequence set_done(b); AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h18 && AVS_WRITEDATA[b]
    && AVS_BYTEENABLE[b >> 3] && !WRITE_PROTECT && !$past(WRITE_PROTECT, 5); endsequence
  a_wait_one: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait");
  a_set_susp: assert property (set_done(9) ##1 SOURCE_FLAGS[9] |=> USB_IRQ) else $error("bit 9");
  a_set_nyet: assert property (set_done(8) ##1 SOURCE_FLAGS[8] |=> USB_IRQ) else $error("bit 8");
  a_set_ram: assert property (set_done(7) ##1 SOURCE_FLAGS[7] |=> USB_IRQ) else $error("bit 7");
  // Flags are sticky, so a rise needs a fresh source or a landed enable set write
  a_irq_source: assert property ($rose(USB_IRQ) |-> $past(SOURCE_FLAGS != 16'h0) ||
    $past(AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h18)) else $error("irq");
  a_prot_hold: assert property (WRITE_PROTECT && $past(WRITE_PROTECT, 5) && !USB_IRQ &&
    $stable(SOURCE_FLAGS) |=> !USB_IRQ) else $error("prot");
  a_read_bits: assert property (rd_done(8'h18) |-> (AVS_READDATA & 32'hfffffc42) == 32'h0) else $error("bits");
  a_clear_mirror: assert property (rd_done(8'h18) ##3 rd_done(8'h14) |-> AVS_READDATA == $past(AVS_READDATA, 3))
    else $error("mirror");
endmodule
bind usb_pipe_desc_irq_enable_set usb_irq_props i_usb_irq_props (.CLK_SYS, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .SOURCE_FLAGS, .WRITE_PROTECT, .USB_IRQ);

// file: usb_pipe_desc_irq_enable_set_tb.sv
`timescale 1ns/1ps
module usb_pipe_desc_irq_enable_set_tb;
  logic [67:0] rows [7] = '{68'h18020018020002001, 68'h18010014030001001, 68'h18000018030000800,
    68'h18008014038000801, 68'h140380180000ffff0, 68'h18ffff1803bd00011, 68'h68beef68beef00000};
  logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, prot = 1'b0, wt, uirq, eirq;
  logic [7:0]  adr = 8'h00;
  logic [15:0] wd = 16'h0000, fl = 16'h0000;
  logic [31:0] q, rdat;
  int          fail_count = 0, compares = 0;
  usb_pipe_desc_irq_enable_set i_usb_pipe_desc_irq_enable_set (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA({16'h0, wd}), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wt), .SOURCE_FLAGS(fl), .WRITE_PROTECT(prot), .USB_IRQ(uirq), .EVENT_IRQ(eirq));
  initial forever #12.5 clk = ~clk;
  task automatic check(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, 8'h18, 16'h0);
    check("rst", q, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, rows[i][67:60], rows[i][59:44]);
      fl <= rows[i][19:4];
      bus(1'b0, rows[i][43:36], 16'h0);
      @(negedge clk);
      check("en", q, {16'h0, rows[i][35:20]});
      check("irq", {31'h0, uirq}, {28'h0, rows[i][3:0]});
      // Flags are sticky: drop the sources, then clear them before the next row
      @(posedge clk);
      fl <= 16'h0000;
      bus(1'b1, 8'h1c, 16'hffff);
      $display("row %0d done", i);
    end
    bus(1'b0, 8'h18, 16'h0);
    bus(1'b0, 8'h14, 16'h0);
    check("clr", q, 32'h3bd);
    bus(1'b0, 8'h30, 16'h0);
    check("gap", q, 32'h0);
    rstn <= 1'b0;
    prot <= 1'b1;
    fl <= 16'h0080;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Protect must be through the synchroniser first
    repeat (6) @(posedge clk);
    bus(1'b1, 8'h18, 16'h0080);
    bus(1'b0, 8'h18, 16'h0);
    check("prot", q, 32'h0);
    bus(1'b0, 8'h28, 16'h0);
    check("wpstat", q, 32'h1);
    prot <= 1'b0;
    fl <= 16'h0001;
    repeat (6) @(negedge clk);
    check("mask", {31'h0, eirq}, 32'h0);
    bus(1'b1, 8'h24, 16'h0001);
    @(negedge clk);
    check("unmask", {31'h0, eirq}, 32'h1);
    bus(1'b0, 8'h20, 16'h0);
    @(negedge clk);
    check("stat", q, 32'h81);
    check("rdclr", {31'h0, eirq}, 32'h0);
    $display("hand tests done");
    close_out;
  end
endmodule
